// ---- core/dsc_cfg.svh ----
// Constants for the dual synthesizer control register bank.
// Included by the package and both ends; definitions only.
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH
`define DSC_WORD_W      22
`define DSC_DATA_W      20
`define DSC_ADDR_W      2
`define DSC_CNT_W       5
`define DSC_LAST_BIT    5'h15
`define DSC_ADDR_IF_REF 2'h0
`define DSC_ADDR_RF_REF 2'h1
`define DSC_ADDR_IF_FB  2'h2
`define DSC_ADDR_RF_FB  2'h3
// Field positions within a 22-bit word
`define DSC_RDIV_LSB    2
`define DSC_RDIV_MSB    16
`define DSC_POL_BIT     17
`define DSC_GAIN_BIT    18
`define DSC_HIZ_BIT     19
`define DSC_SELHI_BIT   20
`define DSC_SELLO_BIT   21
`define DSC_A_LSB       2
`define DSC_A_MSB       8
`define DSC_AIF_MSB     5
`define DSC_B_LSB       9
`define DSC_B_MSB       19
`define DSC_PRE_BIT     20
`define DSC_PD_BIT      21
// Limits
`define DSC_RDIV_MIN    15'h0003
`define DSC_B_MIN       11'h003
// Output selector codes
`define DSC_SEL_LOW     4'h0
`define DSC_SEL_ACQ     4'h3
`define DSC_SEL_IFLD    4'h4
`define DSC_SEL_RST_IF  4'h7
`define DSC_SEL_RFLD    4'h8
`define DSC_SEL_RST_RF  4'hB
`define DSC_SEL_BOTHLD  4'hC
`define DSC_SEL_RST_ALL 4'hF
// Host serial clock divider: half period in clk_i cycles
`define DSC_HALF_DIV    3'h4
// Host register map on the bus: word to send, status
`define DSC_OFS_WORD    4'h0
`define DSC_OFS_STAT    4'h4
`define DSC_WB_SEL_ALL  4'hF
`define DSC_BUSY_BIT    0
`endif

// ---- core/dsc_pkg.sv ----
// Types for the serial programming link; only the host end uses them.
// Assumes dsc_cfg.svh for all widths and codes.
`include "dsc_cfg.svh"
package dsc_pkg;
  typedef logic [`DSC_WORD_W-1:0] dsc_word_t;
  typedef enum logic [1:0] {
    DSC_IDLE,
    DSC_SHIFT,
    DSC_LATCH,
    DSC_GAP
  } dsc_host_e;
endpackage : dsc_pkg

// ---- core/dsc_link_if.sv ----
// Three-wire serial programming link: data, clock, latch enable.
// Host drives all three; device only listens.
`timescale 1ns/1ps
`default_nettype none
interface dsc_link_if;
  logic ser_clk;
  logic ser_data;
  logic latch_enable;
  modport host (output ser_clk, output ser_data, output latch_enable);
  modport device (input ser_clk, input ser_data, input latch_enable);
endinterface : dsc_link_if
`default_nettype wire

// ---- core/dsc_device.sv ----
// Device end: 22-bit shift register on the serial clock, four control
// registers, divider control, powerdown style and output selector.
// Assumes the host keeps the serial clock running through latch pulses.
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dsc_cfg.svh"
module dsc_device (
  // Link side
  dsc_link_if.device             link,
  // Synthesizer side, on the system clock
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              if_pump_pulse_i,
  input  wire logic              rf_pump_pulse_i,
  input  wire logic              if_lock_i,
  input  wire logic              rf_lock_i,
  input  wire logic              if_ref_div_i,
  input  wire logic              rf_ref_div_i,
  input  wire logic              if_fb_div_i,
  input  wire logic              rf_fb_div_i,
  // Decoded controls
  output logic [14:0]            if_reference_divide_ratio_o,
  output logic [14:0]            rf_reference_divide_ratio_o,
  output logic                   if_phase_detector_polarity_o,
  output logic                   rf_phase_detector_polarity_o,
  output logic                   if_charge_pump_gain_o,
  output logic                   rf_charge_pump_gain_o,
  output logic                   if_charge_pump_high_impedance_o,
  output logic                   rf_charge_pump_high_impedance_o,
  output logic [3:0]             if_swallow_count_o,
  output logic [6:0]             rf_swallow_count_o,
  output logic [10:0]            if_binary_count_o,
  output logic [10:0]            rf_binary_count_o,
  output logic                   if_prescaler_sel_o,
  output logic                   rf_prescaler_sel_o,
  output logic                   if_powered_down_o,
  output logic                   rf_powered_down_o,
  output logic                   if_divider_hold_o,
  output logic                   rf_divider_hold_o,
  output logic [3:0]             out_select_o,
  output logic                   mfo_out_o,
  output logic                   mfo_oe_o
);
  // Link-clock domain: shift register and four control words
  logic [`DSC_WORD_W-1:0] shift_reg;
  logic [`DSC_WORD_W-1:0] if_ref_reg;
  logic [`DSC_WORD_W-1:0] rf_ref_reg;
  logic [`DSC_WORD_W-1:0] if_fb_reg;
  logic [`DSC_WORD_W-1:0] rf_fb_reg;
  logic                   le_d_reg;
  wire                    le_rise = link.latch_enable & ~le_d_reg;
  wire [`DSC_ADDR_W-1:0]  wr_addr = shift_reg[`DSC_ADDR_W-1:0];

  // Shift MSB first; latch enable edge seen on the serial clock
  always_ff @(posedge link.ser_clk) begin
    shift_reg <= {shift_reg[`DSC_WORD_W-2:0], link.ser_data};
    le_d_reg  <= link.latch_enable;
  end

  // Only the addressed word changes; no reset pin, power-up is undefined
  always_ff @(posedge link.ser_clk) begin
    if (le_rise && wr_addr == `DSC_ADDR_IF_REF) if_ref_reg <= shift_reg;
    if (le_rise && wr_addr == `DSC_ADDR_RF_REF) rf_ref_reg <= shift_reg;
    if (le_rise && wr_addr == `DSC_ADDR_IF_FB)  if_fb_reg  <= shift_reg;
    if (le_rise && wr_addr == `DSC_ADDR_RF_FB)  rf_fb_reg  <= shift_reg;
  end

  // Latch enable crosses by two flops; its fall marks a settled word
  logic le_s1_reg;
  logic le_s2_reg;
  logic le_s3_reg;
  wire  le_fall = le_s3_reg & ~le_s2_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      le_s1_reg <= 1'b0;
      le_s2_reg <= 1'b0;
      le_s3_reg <= 1'b0;
    end else begin
      le_s1_reg <= link.latch_enable;
      le_s2_reg <= le_s1_reg;
      le_s3_reg <= le_s2_reg;
    end
  end

  // Words cross by two flops; the second copies only after latch enable
  // has fallen, so a word caught mid-change never reaches the decode
  logic [`DSC_WORD_W-1:0] sync1_reg [4];
  logic [`DSC_WORD_W-1:0] sync2_reg [4];
  wire  [`DSC_WORD_W-1:0] src_w [4];
  assign src_w[0] = if_ref_reg;
  assign src_w[1] = rf_ref_reg;
  assign src_w[2] = if_fb_reg;
  assign src_w[3] = rf_fb_reg;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1_reg[gi] <= '0;
          sync2_reg[gi] <= '0;
        end else begin
          sync1_reg[gi] <= src_w[gi];
          sync2_reg[gi] <= le_fall ? sync1_reg[gi] : sync2_reg[gi];
        end
      end
    end
  endgenerate

  // Field decode on the system clock
  wire [`DSC_WORD_W-1:0] ifr = sync2_reg[0];
  wire [`DSC_WORD_W-1:0] rfr = sync2_reg[1];
  wire [`DSC_WORD_W-1:0] ifn = sync2_reg[2];
  wire [`DSC_WORD_W-1:0] rfn = sync2_reg[3];
  wire [3:0] sel_w = {rfr[`DSC_SELHI_BIT], ifr[`DSC_SELHI_BIT],
                      rfr[`DSC_SELLO_BIT], ifr[`DSC_SELLO_BIT]};
  wire rst_if_w = (sel_w == `DSC_SEL_RST_IF) || (sel_w == `DSC_SEL_RST_ALL);
  wire rst_rf_w = (sel_w == `DSC_SEL_RST_RF) || (sel_w == `DSC_SEL_RST_ALL);
  wire if_pd_req = ifn[`DSC_PD_BIT];
  wire rf_pd_req = rfn[`DSC_PD_BIT];
  wire if_hiz    = ifr[`DSC_HIZ_BIT];
  wire rf_hiz    = rfr[`DSC_HIZ_BIT];

  // Powerdown: async style at once, sync style after a pump pulse
  logic if_pd_reg;
  logic rf_pd_reg;
  wire  if_pd_next = !if_pd_req ? 1'b0 :
                     (if_hiz || if_pump_pulse_i) ? 1'b1 : if_pd_reg;
  wire  rf_pd_next = !rf_pd_req ? 1'b0 :
                     (rf_hiz || rf_pump_pulse_i) ? 1'b1 : rf_pd_reg;

  // Output selector mux; divider codes ignore the top bit
  logic mfo_next;
  always_comb begin
    case (sel_w)
      `DSC_SEL_IFLD:   mfo_next = if_lock_i;
      `DSC_SEL_RFLD:   mfo_next = rf_lock_i;
      `DSC_SEL_BOTHLD: mfo_next = if_lock_i & rf_lock_i;
      default: begin
        case (sel_w[2:0])
          3'h1:    mfo_next = if_ref_div_i;
          3'h2:    mfo_next = rf_ref_div_i;
          3'h5:    mfo_next = if_fb_div_i;
          3'h6:    mfo_next = rf_fb_div_i;
          default: mfo_next = 1'b0;
        endcase
      end
    endcase
  end
  // Open-drain acquisition: pulls low while RF pump is high gain
  wire acq_w = (sel_w == `DSC_SEL_ACQ);

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      if_pd_reg                       <= 1'b0;
      rf_pd_reg                       <= 1'b0;
      if_reference_divide_ratio_o     <= '0;
      rf_reference_divide_ratio_o     <= '0;
      if_phase_detector_polarity_o    <= 1'b0;
      rf_phase_detector_polarity_o    <= 1'b0;
      if_charge_pump_gain_o           <= 1'b0;
      rf_charge_pump_gain_o           <= 1'b0;
      if_charge_pump_high_impedance_o <= 1'b0;
      rf_charge_pump_high_impedance_o <= 1'b0;
      if_swallow_count_o              <= '0;
      rf_swallow_count_o              <= '0;
      if_binary_count_o               <= '0;
      rf_binary_count_o               <= '0;
      if_prescaler_sel_o              <= 1'b0;
      rf_prescaler_sel_o              <= 1'b0;
      if_powered_down_o               <= 1'b0;
      rf_powered_down_o               <= 1'b0;
      if_divider_hold_o               <= 1'b0;
      rf_divider_hold_o               <= 1'b0;
      out_select_o                    <= '0;
      mfo_out_o                       <= 1'b0;
      mfo_oe_o                        <= 1'b0;
    end else begin
      if_pd_reg                       <= if_pd_next;
      rf_pd_reg                       <= rf_pd_next;
      if_reference_divide_ratio_o     <= ifr[`DSC_RDIV_MSB:`DSC_RDIV_LSB];
      rf_reference_divide_ratio_o     <= rfr[`DSC_RDIV_MSB:`DSC_RDIV_LSB];
      if_phase_detector_polarity_o    <= ifr[`DSC_POL_BIT];
      rf_phase_detector_polarity_o    <= rfr[`DSC_POL_BIT];
      if_charge_pump_gain_o           <= ifr[`DSC_GAIN_BIT];
      rf_charge_pump_gain_o           <= rfr[`DSC_GAIN_BIT];
      // High impedance also forced in powerdown, without waiting
      if_charge_pump_high_impedance_o <= if_hiz | if_pd_next;
      rf_charge_pump_high_impedance_o <= rf_hiz | rf_pd_next;
      if_swallow_count_o              <= ifn[`DSC_AIF_MSB:`DSC_A_LSB];
      rf_swallow_count_o              <= rfn[`DSC_A_MSB:`DSC_A_LSB];
      if_binary_count_o               <= ifn[`DSC_B_MSB:`DSC_B_LSB];
      rf_binary_count_o               <= rfn[`DSC_B_MSB:`DSC_B_LSB];
      if_prescaler_sel_o              <= ifn[`DSC_PRE_BIT];
      rf_prescaler_sel_o              <= rfn[`DSC_PRE_BIT];
      if_powered_down_o               <= if_pd_next;
      rf_powered_down_o               <= rf_pd_next;
      if_divider_hold_o               <= rst_if_w | if_pd_next;
      rf_divider_hold_o               <= rst_rf_w | rf_pd_next;
      out_select_o                    <= sel_w;
      mfo_out_o                       <= acq_w ? 1'b0 : mfo_next;
      mfo_oe_o                        <= acq_w ? rf_charge_pump_gain_o : 1'b1;
    end
  end
endmodule : dsc_device
`default_nettype wire

// ---- core/dsc_host.sv ----
// Host end: takes a 22-bit word over classic Wishbone and shifts it out
// MSB first on a divided serial clock, then pulses latch enable.
// Assumes the caller only programs legal ratios and counts.
`timescale 1ns/1ps
`default_nettype none
`include "dsc_cfg.svh"
module dsc_host (
  // Link side
  dsc_link_if.host               link,
  // System side
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Classic Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o
);
  dsc_pkg::dsc_host_e     state_reg;
  dsc_pkg::dsc_host_e     state_next;
  logic [`DSC_WORD_W-1:0] word_reg;
  logic [`DSC_CNT_W-1:0]  bit_reg;
  logic [2:0]             div_reg;
  logic                   sclk_reg;
  logic                   le_reg;
  logic                   armed_reg;
  wire                    tick  = (div_reg == `DSC_HALF_DIV - 3'h1);
  wire                    fall  = tick & sclk_reg;
  wire                    rise  = tick & ~sclk_reg;
  wire                    sfall = fall & armed_reg;
  wire                    last  = (bit_reg == `DSC_LAST_BIT);
  wire                    busy  = (state_reg != dsc_pkg::DSC_IDLE);

  // Bus decode; a write lands at the edge that sees ack high
  wire        bus_req   = wb_cyc_i & wb_stb_i;
  wire        bus_hit   = bus_req & wb_ack_o;
  wire        start     = bus_hit & wb_we_i & ~busy & (wb_adr_i == `DSC_OFS_WORD)
                          & (wb_sel_i == `DSC_WB_SEL_ALL);
  wire [31:0] rd_data_w = (wb_adr_i == `DSC_OFS_STAT) ?
                          (32'(busy) << `DSC_BUSY_BIT) : 32'h0;

  assign link.ser_clk      = sclk_reg;
  assign link.ser_data     = word_reg[`DSC_WORD_W-1];
  assign link.latch_enable = le_reg;

  // Next state: data changes on falling clock, latch after last rise
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dsc_pkg::DSC_IDLE:  if (start) state_next = dsc_pkg::DSC_SHIFT;
      dsc_pkg::DSC_SHIFT: if (sfall && last) state_next = dsc_pkg::DSC_LATCH;
      dsc_pkg::DSC_LATCH: if (fall) state_next = dsc_pkg::DSC_GAP;
      dsc_pkg::DSC_GAP:   if (fall) state_next = dsc_pkg::DSC_IDLE;
      default:            state_next = dsc_pkg::DSC_IDLE;
    endcase
  end

  // Serial clock runs free so the device sees the latch edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg  <= 3'h0;
      sclk_reg <= 1'b0;
    end else begin
      div_reg  <= tick ? 3'h0 : div_reg + 3'h1;
      sclk_reg <= tick ? ~sclk_reg : sclk_reg;
    end
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= rd_data_w;
    end
  end

  // Word shifting; no shift before a rise has seen the first bit,
  // since a word can arrive in either half of the serial clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= dsc_pkg::DSC_IDLE;
      word_reg  <= '0;
      bit_reg   <= '0;
      le_reg    <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (start) begin
        word_reg  <= wb_dat_i[`DSC_WORD_W-1:0];
        bit_reg   <= '0;
        armed_reg <= 1'b0;
      end else begin
        if (state_reg == dsc_pkg::DSC_SHIFT && sfall && !last) begin
          word_reg <= {word_reg[`DSC_WORD_W-2:0], 1'b0};
          bit_reg  <= bit_reg + `DSC_CNT_W'(1);
        end
        if (rise) armed_reg <= 1'b1;
      end
      le_reg <= (state_next == dsc_pkg::DSC_LATCH);
    end
  end
endmodule : dsc_host
`default_nettype wire

// ---- tb/dsc_checker.sv ----
// Concurrent checks on the link wires and the selector-driven outputs.
// Instantiated beside the link interface in the bench; clocked by clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "dsc_cfg.svh"
module dsc_checker (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Link wires
  input  wire logic       ser_clk,
  input  wire logic       latch_enable,
  // Device outputs
  input  wire logic [3:0] out_select_o,
  input  wire logic       mfo_out_o,
  input  wire logic       mfo_oe_o,
  input  wire logic       if_divider_hold_o,
  input  wire logic       rf_divider_hold_o,
  input  wire logic       if_powered_down_o,
  input  wire logic       if_charge_pump_high_impedance_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Serial clock high for exactly one half period
  chk_sclk_high_width: assert property ($rose(ser_clk) |->
    ser_clk[*4] ##1 !ser_clk) else $error("serial clock half period wrong");
  // Latch pulse lasts one serial period
  chk_latch_pulse_len: assert property ($rose(latch_enable) |->
    latch_enable[*7] ##[1:2] !latch_enable) else $error("latch pulse length wrong");
  // Selector outputs, judged once the code has settled
  chk_sel_low_drive: assert property ((out_select_o == `DSC_SEL_LOW)[*3] |->
    mfo_oe_o && !mfo_out_o) else $error("low code not driving low");
  chk_acq_never_high: assert property ((out_select_o == `DSC_SEL_ACQ)[*3] |->
    !mfo_out_o) else $error("acquisition output driven high");
  chk_rst_all_hold: assert property ((out_select_o == `DSC_SEL_RST_ALL)[*3] |->
    if_divider_hold_o && rf_divider_hold_o && !mfo_out_o) else $error("reset all not held");
  chk_rst_if_hold: assert property ((out_select_o == `DSC_SEL_RST_IF)[*3] |->
    if_divider_hold_o && !mfo_out_o) else $error("IF counters not held");
  chk_rst_rf_hold: assert property ((out_select_o == `DSC_SEL_RST_RF)[*3] |->
    rf_divider_hold_o && !mfo_out_o) else $error("RF counters not held");
  // Powerdown floats the pump and parks the dividers
  chk_pd_parks_if: assert property (if_powered_down_o[*2] |->
    if_charge_pump_high_impedance_o && if_divider_hold_o) else $error("powerdown not parked");

  cover property ($rose(latch_enable));
  cover property (out_select_o == `DSC_SEL_RST_ALL);
  cover property ($rose(if_powered_down_o));
endmodule : dsc_checker
`default_nettype wire

// ---- tb/test_dual_synth_control_regs.sv ----
// Bench: host end drives the device end over the link; random and corner words.
// Assumes core/ compiled first; fields settle a few clk_i edges before the busy status bit clears.
`timescale 1ns/1ps
`default_nettype none
`include "dsc_cfg.svh"
module test_dual_synth_control_regs;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, upd;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [5:0]  lv;
  logic        if_pump_pulse_i, rf_pump_pulse_i, if_lock_i, rf_lock_i;
  logic        if_ref_div_i, rf_ref_div_i, if_fb_div_i, rf_fb_div_i;
  logic [14:0] if_reference_divide_ratio_o, rf_reference_divide_ratio_o;
  logic        if_phase_detector_polarity_o, rf_phase_detector_polarity_o;
  logic        if_charge_pump_gain_o, rf_charge_pump_gain_o, mfo_out_o, mfo_oe_o;
  logic        if_charge_pump_high_impedance_o, rf_charge_pump_high_impedance_o;
  logic [3:0]  if_swallow_count_o, out_select_o;
  logic [6:0]  rf_swallow_count_o;
  logic [10:0] if_binary_count_o, rf_binary_count_o;
  logic        if_prescaler_sel_o, rf_prescaler_sel_o, if_powered_down_o;
  logic        rf_powered_down_o, if_divider_hold_o, rf_divider_hold_o;
  logic [19:0] sh [4];
  int          n_fail, total_checks, cyc;
  assign {if_lock_i, rf_lock_i, if_ref_div_i, rf_ref_div_i, if_fb_div_i, rf_fb_div_i} = lv;
  dsc_link_if link ();
  dsc_host dsc_host_i (.*);
  dsc_device dsc_device_i (.*);
  dsc_checker dsc_checker_i (.*, .ser_clk(link.ser_clk), .latch_enable(link.latch_enable));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Levels move only on request, so checks see them settled; hang guard
  always @(posedge clk_i) begin
    if (upd)
      lv <= 6'($urandom);
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      $display("BAD %0t run too long", $time);
      report_and_stop();
    end
  end
  task automatic ck(input logic [14:0] g, input logic [14:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask : ck
  // Classic single cycle: request held until ack is seen high
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= `DSC_WB_SEL_ALL;
    wb_dat_i <= wd;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer
  // One word through the host; shadow copy kept for expectations
  task automatic send(input logic [19:0] d, input logic [1:0] a);
    logic [31:0] st;
    sh[a] = d;
    st = 32'h1;
    while (st[`DSC_BUSY_BIT] !== 1'b0) wb_xfer(1'b0, `DSC_OFS_STAT, 32'h0, st);
    wb_xfer(1'b1, `DSC_OFS_WORD, {10'h000, d, a}, st);
    st = 32'h1;
    while (st[`DSC_BUSY_BIT] !== 1'b0) wb_xfer(1'b0, `DSC_OFS_STAT, 32'h0, st);
    repeat (4) @(posedge clk_i);
  endtask : send
  task automatic check_all();
    ck(if_reference_divide_ratio_o, sh[0][14:0], "if ratio");
    ck(rf_reference_divide_ratio_o, sh[1][14:0], "rf ratio");
    ck(if_phase_detector_polarity_o, sh[0][15], "if pol");
    ck(rf_phase_detector_polarity_o, sh[1][15], "rf pol");
    ck(if_charge_pump_gain_o, sh[0][16], "if gain");
    ck(rf_charge_pump_gain_o, sh[1][16], "rf gain");
    ck(if_charge_pump_high_impedance_o, sh[0][17], "if hiz");
    ck(rf_charge_pump_high_impedance_o, sh[1][17], "rf hiz");
    ck(if_swallow_count_o, sh[2][3:0], "if swallow");
    ck(rf_swallow_count_o, sh[3][6:0], "rf swallow");
    ck(if_binary_count_o, sh[2][17:7], "if binary");
    ck(rf_binary_count_o, sh[3][17:7], "rf binary");
    ck(if_prescaler_sel_o, sh[2][18], "if pre");
    ck(rf_prescaler_sel_o, sh[3][18], "rf pre");
    ck(out_select_o, {sh[1][18], sh[0][18], sh[1][19], sh[0][19]}, "select");
  endtask : check_all
  // Expected {level, enable} of the multi-function pin for a code
  function automatic logic [1:0] mfo_exp(input logic [3:0] c);
    case (c)
      4'h3: return {1'b0, sh[1][16]};
      4'h4: return {if_lock_i, 1'b1};
      4'h8: return {rf_lock_i, 1'b1};
      4'hC: return {if_lock_i & rf_lock_i, 1'b1};
      4'h1, 4'h9: return {if_ref_div_i, 1'b1};
      4'h2, 4'hA: return {rf_ref_div_i, 1'b1};
      4'h5, 4'hD: return {if_fb_div_i, 1'b1};
      4'h6, 4'hE: return {rf_fb_div_i, 1'b1};
      default: return 2'b01;
    endcase
  endfunction : mfo_exp
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    logic [14:0] r;
    logic [10:0] b;
    logic [3:0]  c;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {lv, upd, if_pump_pulse_i, rf_pump_pulse_i} = '0;
    {n_fail, total_checks, cyc} = '0;
    void'($urandom(60720));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // Bound values first, then random legal words
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 15'h0003 : (i == 1) ? 15'h7FFF : 15'(3 + $urandom % 32765);
      b = (i == 0) ? 11'h003 : (i == 1) ? 11'h7FF : 11'(3 + $urandom % 2045);
      send({5'($urandom), r}, 2'h0);
      send({5'($urandom), 15'(32770 - r)}, 2'h1);
      send({1'b0, 1'($urandom), b, 7'($urandom)}, 2'h2);
      send({1'b0, 1'($urandom), 11'(2050 - b), (i == 1) ? 7'h7F : 7'($urandom)}, 2'h3);
      check_all();
    end
    $display("test fields done");
    // Every selector code twice, with fresh pin levels each time
    for (int i = 0; i < 32; i++) begin
      c = 4'(i);
      upd <= 1'b1;
      @(posedge clk_i);
      upd <= 1'b0;
      send({c[0], c[2], sh[0][17:0]}, 2'h0);
      send({c[1], c[3], sh[1][17:0]}, 2'h1);
      ck(out_select_o, c, "select");
      ck({mfo_out_o, mfo_oe_o}, mfo_exp(c), "pin");
      ck({if_divider_hold_o, rf_divider_hold_o}, {c == 7 || c == 15, c == 11 || c == 15}, "hold");
    end
    $display("test selector done");
    // Powerdown in both styles, then a write while down
    send({sh[0][19:18], 1'b1, sh[0][16:0]}, 2'h0);
    send({1'b1, sh[2][18:0]}, 2'h2);
    ck({if_powered_down_o, if_charge_pump_high_impedance_o}, 2'b11, "async pd");
    send({sh[1][19:18], 1'b0, sh[1][16:0]}, 2'h1);
    send({1'b1, sh[3][18:0]}, 2'h3);
    ck(rf_powered_down_o, 1'b0, "sync pd early");
    rf_pump_pulse_i <= 1'b1;
    @(posedge clk_i);
    rf_pump_pulse_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    ck({rf_powered_down_o, rf_divider_hold_o}, 2'b11, "sync pd");
    send({sh[0][19:15], 15'h1234}, 2'h0);
    ck(if_reference_divide_ratio_o, 15'h1234, "write while down");
    send({1'b0, sh[2][18:0]}, 2'h2);
    send({1'b0, sh[3][18:0]}, 2'h3);
    ck({if_powered_down_o, rf_powered_down_o}, 2'b00, "wake");
    $display("test powerdown done");
    report_and_stop();
  end
endmodule : test_dual_synth_control_regs
`default_nettype wire
